// *** dv/adc_offset_gain_trim_regs_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module adc_offset_gain_trim_regs_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [2:0] fuse_addr_o;
    logic [15:0] fuse_data_i = 16'h0000;
    logic input_b_sel_i = 1'b0;
    logic [11:0] core_b_offset_o;
    logic offset_apply_o;
    ogt_pkg::ogt_gain_type gain_trim_o;
    logic gain_apply_o;
    logic loaded_o;
    int mismatches = 0;
    int n_compared = 0;
    logic [31:0] rd_v;
    logic [9:0] idx_tab [6];
    logic [3:0] sel_tab [6] = '{4'h3, 4'h3, 4'h1, 4'h1, 4'h1, 4'h1};
    logic [15:0] fuse_rom [6] = '{16'ha5c3, 16'h3e71, 16'h0015, 16'h000a, 16'h001f, 16'h0011};
    logic [15:0] wr_tab [6] = '{16'h5abc, 16'hc0de, 16'h00f7, 16'h00e9, 16'h00b6, 16'h0082};

    // Bus clock, 100 MHz
    always #5 clk_i = ~clk_i;

    // Fuse image answers one cycle after the address shows
    always @(posedge clk_i) fuse_data_i <= fuse_rom[fuse_addr_o];

    ogt_trim_regs i_dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .fuse_addr_o(fuse_addr_o),
        .fuse_data_i(fuse_data_i),
        .input_b_sel_i(input_b_sel_i),
        .core_b_offset_o(core_b_offset_o),
        .offset_apply_o(offset_apply_o),
        .gain_trim_o(gain_trim_o),
        .gain_apply_o(gain_apply_o),
        .loaded_o(loaded_o)
    );

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One classic cycle; holds the request until ack is sampled high
    task automatic wb_access(input logic we, input logic [9:0] idx, input logic [3:0] sel,
                             input logic [31:0] wdat, output logic [31:0] rdat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= wdat;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [3:0] sel, input logic [15:0] d);
        wb_access(1'b1, idx, sel, {16'hffff, d}, rd_v);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input string name);
        wb_access(1'b0, idx, 4'hf, 32'h00000000, rd_v);
        check(name, exp, rd_v);
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        conclude();
    end

    // Main sequence
    initial begin
        idx_tab = '{ogt_pkg::OFS_A_IDX, ogt_pkg::OFS_B_IDX, ogt_pkg::GAIN_A0_IDX,
                    ogt_pkg::GAIN_A1_IDX, ogt_pkg::GAIN_B0_IDX, ogt_pkg::GAIN_B1_IDX};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // First reads wait out the fuse load and see the fused defaults
        for (int i = 0; i < 6; i++) rd(idx_tab[i], {16'h0000, fuse_rom[i]}, "fuse default");
        check("loaded", 32'h1, {31'h0, loaded_o});
        rd(ogt_pkg::STAT_IDX, 32'h1, "status");
        // Every bit, reserved ones too, is stored and read back
        for (int i = 0; i < 6; i++) wr(idx_tab[i], sel_tab[i], wr_tab[i]);
        for (int i = 0; i < 6; i++) rd(idx_tab[i], {16'h0000, wr_tab[i]}, "readback");
        // A hole between the two offsets reads zero and keeps its neighbour intact
        wr(10'h34d, 4'h3, 16'h1234);
        rd(10'h34d, 32'h0, "unmapped");
        rd(ogt_pkg::OFS_B_IDX, {16'h0000, wr_tab[1]}, "neighbour");
        // Every mode pair against both inputs
        for (int c = 0; c < 4; c++) begin
            wr(ogt_pkg::CTRL_IDX, 4'h1, 16'(c));
            for (int s = 0; s < 2; s++) begin
                input_b_sel_i <= s[0];
                repeat (3) @(posedge clk_i);
                check("offset", c[0] ? {20'h0, wr_tab[s][11:0]} : 32'h0, {20'h0, core_b_offset_o});
                check("offset apply", {31'h0, c[0]}, {31'h0, offset_apply_o});
                check("gain", c[1] ? {12'h0, wr_tab[2][4:0], wr_tab[3][4:0], wr_tab[4][4:0], wr_tab[5][4:0]}
                      : 32'h0, {12'h0, gain_trim_o});
                check("gain apply", {31'h0, c[1]}, {31'h0, gain_apply_o});
            end
        end
        // Byte lanes: only enabled bytes change, also while the offset is applied
        wr(ogt_pkg::OFS_A_IDX, 4'h2, 16'h9911);
        wr(ogt_pkg::OFS_B_IDX, 4'h1, 16'h7755);
        wr(ogt_pkg::GAIN_A0_IDX, 4'h2, 16'h0033);
        rd(ogt_pkg::OFS_A_IDX, 32'h0000_99bc, "high lane");
        rd(ogt_pkg::OFS_B_IDX, 32'h0000_c055, "low lane");
        rd(ogt_pkg::GAIN_A0_IDX, {16'h0000, wr_tab[2]}, "no lane");
        check("offset live", 32'h0000_0055, {20'h0, core_b_offset_o});
        // Reset in mid-run clears the applied trims and reloads the fuse defaults
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check("apply in reset", 32'h0, {30'h0, offset_apply_o, gain_apply_o});
        rst_i <= 1'b0;
        rd(ogt_pkg::OFS_A_IDX, {16'h0000, fuse_rom[0]}, "reload");
        rd(ogt_pkg::GAIN_B1_IDX, {16'h0000, fuse_rom[5]}, "reload");
        rd(ogt_pkg::CTRL_IDX, 32'h0, "ctrl reset");
        conclude();
    end
endmodule

`default_nettype wire

// *** logic/ogt_fuse_loader.sv ***
`timescale 1ns/100ps
`default_nettype none

module ogt_fuse_loader (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic [2:0] fuse_addr_o,
    input wire logic [15:0] fuse_data_i,
    output ogt_pkg::ogt_load_type load_o,
    output logic done_o
);

    typedef enum logic [1:0] {ADDR, TAKE, DONE} ogt_fuse_state_type;

    ogt_fuse_state_type state_r;
    logic [2:0] idx_r;

    // Walk the fuse image once after every reset; fuse reads take one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ADDR;
            idx_r <= 3'h0;
            load_o <= '0;
            done_o <= 1'b0;
        end else begin
            load_o.we <= 1'b0;
            case (state_r)
                ADDR: begin
                    state_r <= TAKE;
                end
                TAKE: begin
                    load_o.we <= 1'b1;
                    load_o.sel <= idx_r;
                    load_o.data <= fuse_data_i;
                    if (idx_r == ogt_pkg::FUSE_ENTRIES - 3'h1) begin
                        state_r <= DONE;
                    end else begin
                        idx_r <= idx_r + 3'h1;
                        state_r <= ADDR;
                    end
                end
                DONE: begin
                    done_o <= 1'b1;
                end
                default: begin
                    state_r <= DONE;
                end
            endcase
        end
    end

    assign fuse_addr_o = idx_r;

endmodule

`default_nettype wire

// *** logic/ogt_pkg.sv ***
package ogt_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] OFS_A_IDX = 10'h34c;
    localparam logic [9:0] OFS_B_IDX = 10'h34e;
    localparam logic [9:0] GAIN_A0_IDX = 10'h350;
    localparam logic [9:0] GAIN_A1_IDX = 10'h351;
    localparam logic [9:0] GAIN_B0_IDX = 10'h352;
    localparam logic [9:0] GAIN_B1_IDX = 10'h353;
    localparam logic [9:0] CTRL_IDX = 10'h360;
    localparam logic [9:0] STAT_IDX = 10'h361;

    // Field layout
    localparam int OFS_VAL_MSB = 11;
    localparam int GAIN_VAL_MSB = 4;
    localparam int CTRL_FG_CAL_BIT = 0;
    localparam int CTRL_DUAL_BIT = 1;
    localparam int STAT_DONE_BIT = 0;

    // Reset values
    localparam logic [15:0] OFS_RST = 16'h0000;
    localparam logic [7:0] GAIN_RST = 8'h00;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // Fuse image: entries 0..1 offsets, 2..5 gains
    localparam logic [2:0] FUSE_ENTRIES = 3'h6;
    localparam logic [2:0] FUSE_GAIN_BASE = 3'h2;

    // Trims handed to the converter cores
    typedef struct packed {
        logic [4:0] a0;
        logic [4:0] a1;
        logic [4:0] b0;
        logic [4:0] b1;
    } ogt_gain_type;

    // One default value leaving the fuse loader
    typedef struct packed {
        logic       we;
        logic [2:0] sel;
        logic [15:0] data;
    } ogt_load_type;

endpackage

// *** logic/ogt_trim_regs.sv ***
// Local design decision: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Offset for core B on input A, twelve low bits, read-write, four reserved bits above.
// - Offset for core B on input B, twelve low bits, read-write, four reserved bits above.
// - Core B offset applied in both modes, chosen by sampled input, only with calibration on.
// - Five-bit fine gain for core A bank 0, dual mode; three reserved bits; reset zero.
// - Five-bit fine gain for core A bank 1, dual mode; three reserved bits.
// - Five-bit fine gain for core B bank 0, dual mode; three reserved bits.
// - Fine gain for core B bank 1, dual mode; reset value zero.
// - All six trim registers take their default contents from the fuse image.
module ogt_trim_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [2:0] fuse_addr_o,
    input wire logic [15:0] fuse_data_i,
    input wire logic input_b_sel_i,
    output logic [11:0] core_b_offset_o,
    output logic offset_apply_o,
    output ogt_pkg::ogt_gain_type gain_trim_o,
    output logic gain_apply_o,
    output logic loaded_o
);

    logic [15:0] ofs_r [2];
    logic [7:0] gain_r [4];
    logic [1:0] ctrl_r;
    logic [2:0] fuse_addr;
    ogt_pkg::ogt_load_type load;
    logic load_done;
    logic [1:0] hit_ofs;
    logic [3:0] hit_gain;
    logic hit_ctrl;
    logic hit_stat;
    logic bus_go;
    logic wr_go;
    logic [31:0] rd_nxt;
    logic [9:0] idx;

    // Default values from the fuse image
    ogt_fuse_loader u_fuse (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fuse_addr_o(fuse_addr),
        .fuse_data_i(fuse_data_i),
        .load_o(load),
        .done_o(load_done)
    );

    assign fuse_addr_o = fuse_addr;

    // The bus is held off until the defaults are in, so loads never race writes
    assign bus_go = wb_cyc_i && wb_stb_i && !wb_ack_o && load_done;
    assign wr_go = bus_go && wb_we_i;
    assign idx = wb_adr_i[11:2];

    // Address decode
    always_comb begin
        hit_ofs = 2'h0;
        hit_gain = 4'h0;
        hit_ctrl = 1'b0;
        hit_stat = 1'b0;
        case (idx)
            ogt_pkg::OFS_A_IDX: hit_ofs[0] = 1'b1;
            ogt_pkg::OFS_B_IDX: hit_ofs[1] = 1'b1;
            ogt_pkg::GAIN_A0_IDX: hit_gain[0] = 1'b1;
            ogt_pkg::GAIN_A1_IDX: hit_gain[1] = 1'b1;
            ogt_pkg::GAIN_B0_IDX: hit_gain[2] = 1'b1;
            ogt_pkg::GAIN_B1_IDX: hit_gain[3] = 1'b1;
            ogt_pkg::CTRL_IDX: hit_ctrl = 1'b1;
            ogt_pkg::STAT_IDX: hit_stat = 1'b1;
            default: hit_stat = 1'b0;
        endcase
    end

    // Offset registers, whole 16 bits stored, reserved bits included
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ofs
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    ofs_r[gi] <= ogt_pkg::OFS_RST;
                end else if (load.we && load.sel == 3'(gi)) begin
                    ofs_r[gi] <= load.data;
                end else if (wr_go && hit_ofs[gi]) begin
                    if (wb_sel_i[0]) begin
                        ofs_r[gi][7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        ofs_r[gi][15:8] <= wb_dat_i[15:8];
                    end
                end
            end
        end
    endgenerate

    // Fine gain registers, whole byte stored
    generate
        for (gi = 0; gi < 4; gi++) begin : g_gain
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    gain_r[gi] <= ogt_pkg::GAIN_RST;
                end else if (load.we && load.sel == ogt_pkg::FUSE_GAIN_BASE + 3'(gi)) begin
                    gain_r[gi] <= load.data[7:0];
                end else if (wr_go && hit_gain[gi] && wb_sel_i[0]) begin
                    gain_r[gi] <= wb_dat_i[7:0];
                end
            end
        end
    endgenerate

    // Mode control: calibration enable and dual-channel select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= ogt_pkg::CTRL_RST;
        end else if (wr_go && hit_ctrl && wb_sel_i[0]) begin
            ctrl_r <= wb_dat_i[1:0];
        end
    end

    // Read data mux; unmapped addresses read zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (hit_ofs[0]) begin
            rd_nxt[15:0] = ofs_r[0];
        end else if (hit_ofs[1]) begin
            rd_nxt[15:0] = ofs_r[1];
        end else if (hit_gain[0]) begin
            rd_nxt[7:0] = gain_r[0];
        end else if (hit_gain[1]) begin
            rd_nxt[7:0] = gain_r[1];
        end else if (hit_gain[2]) begin
            rd_nxt[7:0] = gain_r[2];
        end else if (hit_gain[3]) begin
            rd_nxt[7:0] = gain_r[3];
        end else if (hit_ctrl) begin
            rd_nxt[1:0] = ctrl_r;
        end else if (hit_stat) begin
            rd_nxt[ogt_pkg::STAT_DONE_BIT] = load_done;
        end
    end

    // Bus answer: one-cycle ack, every address answered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_go;
            if (bus_go && !wb_we_i) begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

    // Core B offset steering
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_b_offset_o <= 12'h000;
            offset_apply_o <= 1'b0;
        end else if (ctrl_r[ogt_pkg::CTRL_FG_CAL_BIT] && load_done) begin
            offset_apply_o <= 1'b1;
            if (input_b_sel_i) begin
                core_b_offset_o <= ofs_r[1][ogt_pkg::OFS_VAL_MSB:0];
            end else begin
                core_b_offset_o <= ofs_r[0][ogt_pkg::OFS_VAL_MSB:0];
            end
        end else begin
            core_b_offset_o <= 12'h000;
            offset_apply_o <= 1'b0;
        end
    end

    // Fine gain steering, dual-channel only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gain_trim_o <= '0;
            gain_apply_o <= 1'b0;
        end else if (ctrl_r[ogt_pkg::CTRL_DUAL_BIT] && load_done) begin
            gain_apply_o <= 1'b1;
            gain_trim_o.a0 <= gain_r[0][ogt_pkg::GAIN_VAL_MSB:0];
            gain_trim_o.a1 <= gain_r[1][ogt_pkg::GAIN_VAL_MSB:0];
            gain_trim_o.b0 <= gain_r[2][ogt_pkg::GAIN_VAL_MSB:0];
            gain_trim_o.b1 <= gain_r[3][ogt_pkg::GAIN_VAL_MSB:0];
        end else begin
            gain_trim_o <= '0;
            gain_apply_o <= 1'b0;
        end
    end

    // Loader status out
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loaded_o <= 1'b0;
        end else begin
            loaded_o <= load_done;
        end
    end

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_ofs_a_write: assert property (
        wr_go && hit_ofs[0] && wb_sel_i[1:0] == 2'h3 |=> ofs_r[0] == $past(wb_dat_i[15:0]))
        else $error("offset A write not stored");

    chk_ofs_b_write: assert property (
        wr_go && hit_ofs[1] && wb_sel_i[1:0] == 2'h3 |=> ofs_r[1] == $past(wb_dat_i[15:0]))
        else $error("offset B write not stored");

    chk_ofs_b_choice: assert property (
        ctrl_r[ogt_pkg::CTRL_FG_CAL_BIT] && load_done && input_b_sel_i
        |=> offset_apply_o && core_b_offset_o == $past(ofs_r[1][ogt_pkg::OFS_VAL_MSB:0]))
        else $error("offset for input B not applied");

    chk_ofs_a_choice: assert property (
        ctrl_r[ogt_pkg::CTRL_FG_CAL_BIT] && load_done && !input_b_sel_i
        |=> offset_apply_o && core_b_offset_o == $past(ofs_r[0][ogt_pkg::OFS_VAL_MSB:0]))
        else $error("offset for input A not applied");

    chk_ofs_gate_off: assert property (
        !ctrl_r[0] |=> core_b_offset_o == 12'h000 && !offset_apply_o)
        else $error("offset applied with calibration off");

    chk_gain_a0_write: assert property (
        wr_go && hit_gain[0] && wb_sel_i[0] |=> gain_r[0] == $past(wb_dat_i[7:0]))
        else $error("gain A0 write not stored");

    chk_gain_a1_write: assert property (
        wr_go && hit_gain[1] && wb_sel_i[0] |=> gain_r[1] == $past(wb_dat_i[7:0]))
        else $error("gain A1 write not stored");

    chk_gain_b0_write: assert property (
        wr_go && hit_gain[2] && wb_sel_i[0] |=> gain_r[2] == $past(wb_dat_i[7:0]))
        else $error("gain B0 write not stored");

    chk_gain_b1_write: assert property (
        wr_go && hit_gain[3] && wb_sel_i[0] |=> gain_r[3] == $past(wb_dat_i[7:0]))
        else $error("gain B1 write not stored");

    chk_fuse_default: assert property (
        load.we && load.sel == 3'h5 |=> gain_r[3] == $past(load.data[7:0]) ##[1:3] load_done)
        else $error("fuse default not loaded");

    chk_rsvd_readback: assert property (
        bus_go && !wb_we_i && hit_ofs[0] |=> wb_ack_o && wb_dat_o == {16'h0000, $past(ofs_r[0])})
        else $error("offset A readback wrong");

    chk_gain_dual_only: assert property (
        !ctrl_r[1] |=> gain_trim_o == '0 && !gain_apply_o)
        else $error("gain trims driven outside dual mode");

    chk_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // Byte lanes and reserved bits
    chk_ofs_high_lane: assert property (
        wr_go && hit_ofs[0] && wb_sel_i[1:0] == 2'h2
        |=> ofs_r[0] == {$past(wb_dat_i[15:8]), $past(ofs_r[0][7:0])})
        else $error("offset A high byte write wrong");

    chk_ofs_low_lane: assert property (
        wr_go && hit_ofs[1] && wb_sel_i[1:0] == 2'h1
        |=> ofs_r[1] == {$past(ofs_r[1][15:8]), $past(wb_dat_i[7:0])})
        else $error("offset B low byte write wrong");

    chk_gain_no_lane: assert property (
        wr_go && hit_gain[0] && !wb_sel_i[0] |=> $stable(gain_r[0]))
        else $error("gain A0 changed with its lane off");

    chk_ofs_hold: assert property (
        !load.we && !(wr_go && hit_ofs[1]) |=> $stable(ofs_r[1]))
        else $error("offset B changed without a write");

    chk_gain_hold: assert property (
        !load.we && !(wr_go && hit_gain[3]) |=> $stable(gain_r[3]))
        else $error("gain B1 changed without a write");

    // Fuse defaults
    chk_fuse_ofs_a: assert property (
        load.we && load.sel == 3'h0 |=> ofs_r[0] == $past(load.data))
        else $error("offset A fuse default not loaded");

    chk_fuse_ofs_b: assert property (
        load.we && load.sel == 3'h1 |=> ofs_r[1] == $past(load.data))
        else $error("offset B fuse default not loaded");

    chk_fuse_gain_a0: assert property (
        load.we && load.sel == ogt_pkg::FUSE_GAIN_BASE |=> gain_r[0] == $past(load.data[7:0]))
        else $error("gain A0 fuse default not loaded");

    chk_loaded_copy: assert property (
        loaded_o == $past(load_done))
        else $error("loaded flag does not follow the loader");

    // Applied gains carry the stored five-bit fields
    chk_gain_applied: assert property (
        ctrl_r[ogt_pkg::CTRL_DUAL_BIT] && load_done
        |=> gain_apply_o && gain_trim_o == {$past(gain_r[0][4:0]), $past(gain_r[1][4:0]),
                                            $past(gain_r[2][4:0]), $past(gain_r[3][4:0])})
        else $error("gains not applied in dual mode");

    // Bus answers
    chk_ack_answer: assert property (
        bus_go |=> wb_ack_o)
        else $error("request not acknowledged");

    chk_ack_stalled: assert property (
        !load_done |=> !wb_ack_o)
        else $error("ack given before fuse defaults loaded");

    chk_unmapped_zero: assert property (
        bus_go && !wb_we_i && !(|hit_ofs) && !(|hit_gain) && !hit_ctrl && !hit_stat
        |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    chk_stat_read: assert property (
        bus_go && !wb_we_i && hit_stat |=> wb_dat_o == {31'h0, $past(load_done)})
        else $error("status read wrong");

    chk_ctrl_write: assert property (
        wr_go && hit_ctrl && wb_sel_i[0] |=> ctrl_r == $past(wb_dat_i[1:0]))
        else $error("control write not stored");

    cov_fuse_done: cover property ($rose(load_done));
    cov_offset_swap: cover property (offset_apply_o && input_b_sel_i ##1 !input_b_sel_i);
    cov_gain_write: cover property (wr_go && |hit_gain ##1 wb_ack_o);
    cov_read_back: cover property (bus_go && !wb_we_i && hit_ofs[1]);
    cov_lane_write: cover property (wr_go && |hit_ofs && wb_sel_i[1:0] != 2'h3);

endmodule

`default_nettype wire
